// *** inc/ain_scale_pkg.sv ***
// Purpose: shared constants and types for the analog input scaling block
// Assumes: object dictionary entries addressed by 16-bit index and 8-bit subindex
// Notes:   channel 2 exists only when the fitted strap is high after reset
package ain_scale_pkg;

   // object dictionary indices and subindices
   localparam logic [15:0] IDX_VALUE   = 16'h3320;
   localparam logic [15:0] IDX_OFFSET  = 16'h3321;
   localparam logic [15:0] IDX_MULT    = 16'h3322;
   localparam logic [15:0] IDX_DIVISOR = 16'h3323;
   localparam logic [7:0]  SUB_COUNT   = 8'h00;
   localparam logic [7:0]  SUB_CH1     = 8'h01;
   localparam logic [7:0]  SUB_CH2     = 8'h02;

   // entry counts and reset values
   localparam logic [7:0]  COUNT_BASE  = 8'h01;
   localparam logic [7:0]  COUNT_FULL  = 8'h02;
   localparam logic [15:0] OFFSET_RST  = 16'h0000;
   localparam logic [15:0] MULT_RST    = 16'h0FFF;
   localparam logic [15:0] DIVISOR_RST = 16'h0FFF;
   localparam logic [31:0] VALUE_RST   = 32'h0000_0000;

   // datapath sizes
   localparam int          CH_NUM      = 2;
   localparam int          ADC_W       = 10;
   localparam logic [5:0]  DIV_STEPS   = 6'h21;  // one step per bit of the 33-bit product
   localparam logic [1:0]  STRAP_FILL  = 2'h3;   // cycles to fill the strap synchroniser

   // current input scale: full scale in uA over the top converter count
   localparam int          CUR_FS_UA   = 20000;
   localparam int          CUR_MAX_CNT = 1023;

   typedef enum logic [1:0] {ST_IDLE, ST_DIV, ST_STORE} phase_t;

   // per-channel parameters, presented value and pending raw sample
   typedef struct packed {
      logic [15:0]      offset;
      logic [15:0]      mult;
      logic [15:0]      divisor;
      logic [31:0]      value;
      logic [ADC_W-1:0] raw;
      logic             pend;
   } chan_t;

   // object dictionary request and answer
   typedef struct packed {
      logic        rd;
      logic        wr;
      logic [15:0] index;
      logic [7:0]  sub;
      logic [31:0] wdata;
   } od_req_t;

   typedef struct packed {
      logic        ack;
      logic        err;
      logic [31:0] rdata;
   } od_rsp_t;

   // converter sample strobe
   typedef struct packed {
      logic             valid;
      logic             chan;
      logic [ADC_W-1:0] data;
   } adc_smp_t;

endpackage

// *** src/ain_scale.sv ***
// Purpose: offset, multiply and divide each converter reading into a user-unit value
// Assumes: samples and dictionary requests come from logic on core_clk
// Notes:   one shared serial divider; a newer sample replaces an unprocessed one
//
// How it works
// - each channel value is refreshed from its latest converter sample when its denominator is nonzero
// - signed offset is added to the raw reading before any scaling
// - offset-corrected reading is multiplied by the channel numerator
// - the product is divided by the channel denominator before storing
// - default offset, numerator and denominator leave the raw count unchanged
// - current input: one count is 20 mA over 1023, linear mapping
// - channel values are signed 32-bit read-only, zero after reset
// - offsets are signed 16-bit read/write, zero after reset
// - numerators are signed 16-bit read/write, default multiplier after reset
// - read-only entry count reports channels, resets to one
// - a fitted second channel has its own value and parameters
`timescale 1ns/10ps
`default_nettype none

module ain_scale (
   input  wire logic                    core_clk,
   input  wire logic                    rst_n,
   input  wire ain_scale_pkg::adc_smp_t adc_smp,
   input  wire logic                    ch2_fitted_strap,
   input  wire ain_scale_pkg::od_req_t  od_req,
   output var  ain_scale_pkg::od_rsp_t  od_rsp,
   output logic [31:0]                  ch1_value,
   output logic [31:0]                  ch2_value,
   output logic [7:0]                   entry_count
);

   // every flip-flop of the block lives in this one struct
   typedef struct packed {
      ain_scale_pkg::chan_t [ain_scale_pkg::CH_NUM-1:0] ch;
      ain_scale_pkg::phase_t                            phase;
      logic                                             cur;
      logic                                             neg;
      logic [32:0]                                      dvd;
      logic [15:0]                                      dmag;
      logic [16:0]                                      rem;
      logic [32:0]                                      quo;
      logic [5:0]                                       step;
      logic [2:0]                                       strap_sync;
      logic [1:0]                                       strap_fill;
      logic                                             strap_done;
      logic                                             fitted;
      logic [7:0]                                       count;
      ain_scale_pkg::od_rsp_t                           rsp;
   } state_t;

   state_t st_r;
   state_t st_nxt;

   // datapath scratch
   logic signed [16:0] sum;
   logic signed [32:0] prod;
   logic [32:0]        pmag;
   logic [16:0]        trial;
   logic [32:0]        res;
   logic               sel;
   logic               hit;
   logic               chan_ok;
   logic               ch_idx;

   // next-state logic: sampling, scaling sequence, strap capture, dictionary access
   always_comb begin
      st_nxt  = st_r;
      sum     = '0;
      prod    = '0;
      pmag    = '0;
      trial   = '0;
      res     = '0;
      sel     = 1'b0;
      hit     = 1'b0;
      chan_ok = 1'b0;
      ch_idx  = 1'b0;

      // strap passes three flops and is caught once the last two agree
      st_nxt.strap_sync = {st_r.strap_sync[1:0], ch2_fitted_strap};
      if (!st_r.strap_done) begin
         if (st_r.strap_fill != ain_scale_pkg::STRAP_FILL) begin
            st_nxt.strap_fill = st_r.strap_fill + 2'h1;
         end else if (st_r.strap_sync[1] == st_r.strap_sync[2]) begin
            st_nxt.strap_done = 1'b1;
            st_nxt.fitted     = st_r.strap_sync[2];
            st_nxt.count      = st_r.strap_sync[2] ? ain_scale_pkg::COUNT_FULL
                                                   : ain_scale_pkg::COUNT_BASE;
         end
      end

      // scaling sequence on the shared divider
      unique case (st_r.phase)
         ain_scale_pkg::ST_IDLE: begin
            sel = !st_r.ch[0].pend;  // channel 1 first, channel 2 when 1 is idle
            if (st_r.ch[sel].pend) begin
               st_nxt.ch[sel].pend = 1'b0;
               st_nxt.cur          = sel;
               // offset first, then numerator; a 10-bit count plus any 16-bit
               // offset fits the 17-bit sum, and the 33-bit product holds any
               // 17 by 16 signed pair, so nothing is lost before the divide
               // a current input loads full scale as numerator and the top count
               // as denominator, giving a linear count-to-current mapping
               sum  = 17'(signed'({7'h00, st_r.ch[sel].raw}))
                    + 17'(signed'(st_r.ch[sel].offset));
               prod = 33'(sum) * 33'(signed'(st_r.ch[sel].mult));
               pmag = prod[32] ? 33'(-prod) : 33'(prod);
               if (st_r.ch[sel].divisor != 16'h0000) begin
                  st_nxt.neg   = prod[32] ^ st_r.ch[sel].divisor[15];
                  st_nxt.dvd   = pmag;
                  st_nxt.dmag  = st_r.ch[sel].divisor[15] ? 16'(-st_r.ch[sel].divisor)
                                                          : st_r.ch[sel].divisor;
                  st_nxt.rem   = '0;
                  st_nxt.quo   = '0;
                  st_nxt.step  = '0;
                  st_nxt.phase = ain_scale_pkg::ST_DIV;
               end
            end
         end
         ain_scale_pkg::ST_DIV: begin
            // restoring division on magnitudes, one quotient bit per cycle
            trial = {st_r.rem[15:0], st_r.dvd[32]};
            st_nxt.dvd = {st_r.dvd[31:0], 1'b0};
            if (trial >= {1'b0, st_r.dmag}) begin
               st_nxt.rem = trial - {1'b0, st_r.dmag};
               st_nxt.quo = {st_r.quo[31:0], 1'b1};
            end else begin
               st_nxt.rem = trial;
               st_nxt.quo = {st_r.quo[31:0], 1'b0};
            end
            st_nxt.step = st_r.step + 6'h01;
            if (st_r.step == ain_scale_pkg::DIV_STEPS - 6'h01) begin
               st_nxt.phase = ain_scale_pkg::ST_STORE;
            end
         end
         ain_scale_pkg::ST_STORE: begin
            // quotient truncates toward zero; out-of-range results wrap to 32 bits
            res = st_r.neg ? 33'(-st_r.quo) : st_r.quo;
            st_nxt.ch[st_r.cur].value = res[31:0];
            st_nxt.phase              = ain_scale_pkg::ST_IDLE;
         end
         default: begin
            st_nxt.phase = ain_scale_pkg::ST_IDLE;
         end
      endcase

      // a new sample after the clear above, so a same-cycle arrival is kept
      if (adc_smp.valid && (!adc_smp.chan || st_r.fitted)) begin
         st_nxt.ch[adc_smp.chan].raw  = adc_smp.data;
         st_nxt.ch[adc_smp.chan].pend = 1'b1;
      end

      // dictionary access: answer one cycle after the request
      // a read and a write in one cycle are served as the read alone
      st_nxt.rsp.ack = od_req.rd || od_req.wr;
      st_nxt.rsp.err = 1'b0;
      if (od_req.rd || od_req.wr) begin
         st_nxt.rsp.rdata = '0;
      end
      chan_ok = (od_req.sub == ain_scale_pkg::SUB_CH1)
             || (od_req.sub == ain_scale_pkg::SUB_CH2 && st_r.fitted);
      ch_idx  = (od_req.sub == ain_scale_pkg::SUB_CH2);
      hit     = (od_req.index == ain_scale_pkg::IDX_VALUE)
             || (od_req.index == ain_scale_pkg::IDX_OFFSET)
             || (od_req.index == ain_scale_pkg::IDX_MULT)
             || (od_req.index == ain_scale_pkg::IDX_DIVISOR);
      if (od_req.rd) begin
         if (!hit) begin
            st_nxt.rsp.err = 1'b1;
         end else if (od_req.sub == ain_scale_pkg::SUB_COUNT) begin
            st_nxt.rsp.rdata = {24'h000000, st_r.count};
         end else if (!chan_ok) begin
            st_nxt.rsp.err = 1'b1;
         end else if (od_req.index == ain_scale_pkg::IDX_VALUE) begin
            st_nxt.rsp.rdata = st_r.ch[ch_idx].value;
         end else if (od_req.index == ain_scale_pkg::IDX_OFFSET) begin
            st_nxt.rsp.rdata = {{16{st_r.ch[ch_idx].offset[15]}}, st_r.ch[ch_idx].offset};
         end else if (od_req.index == ain_scale_pkg::IDX_MULT) begin
            st_nxt.rsp.rdata = {{16{st_r.ch[ch_idx].mult[15]}}, st_r.ch[ch_idx].mult};
         end else begin
            st_nxt.rsp.rdata = {{16{st_r.ch[ch_idx].divisor[15]}}, st_r.ch[ch_idx].divisor};
         end
      end else if (od_req.wr) begin
         // counts and values refuse writes; parameters take the low 16 bits
         if (!hit || od_req.sub == ain_scale_pkg::SUB_COUNT || !chan_ok
             || od_req.index == ain_scale_pkg::IDX_VALUE) begin
            st_nxt.rsp.err = 1'b1;
         end else if (od_req.index == ain_scale_pkg::IDX_OFFSET) begin
            st_nxt.ch[ch_idx].offset = od_req.wdata[15:0];
         end else if (od_req.index == ain_scale_pkg::IDX_MULT) begin
            st_nxt.ch[ch_idx].mult = od_req.wdata[15:0];
         end else begin
            st_nxt.ch[ch_idx].divisor = od_req.wdata[15:0];
         end
      end
   end

   // single state register; reset loads constants only
   // values clear at reset, so a read before the first result gives zero
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_r            <= '0;
         st_r.phase      <= ain_scale_pkg::ST_IDLE;
         st_r.count      <= ain_scale_pkg::COUNT_BASE;
         for (int i = 0; i < ain_scale_pkg::CH_NUM; i++) begin
            st_r.ch[i].offset  <= ain_scale_pkg::OFFSET_RST;
            st_r.ch[i].mult    <= ain_scale_pkg::MULT_RST;
            st_r.ch[i].divisor <= ain_scale_pkg::DIVISOR_RST;
            st_r.ch[i].value   <= ain_scale_pkg::VALUE_RST;
         end
      end else begin
         st_r <= st_nxt;
      end
   end

   // outputs are fields of the state register
   assign od_rsp      = st_r.rsp;
   assign ch1_value   = st_r.ch[0].value;
   assign ch2_value   = st_r.ch[1].value;
   assign entry_count = st_r.count;

endmodule // ain_scale

`default_nettype wire

// *** verification/ain_scale_props.sv ***
// Purpose: port-level checks of the analog input scaling block
// Assumes: one clock, async active-low reset
// Notes:   sees only top-level ports, attached by bind
`timescale 1ns/10ps
`default_nettype none
module ain_scale_props (
   input wire logic                    core_clk,
   input wire logic                    rst_n,
   input wire ain_scale_pkg::adc_smp_t adc_smp,
   input wire logic                    ch2_fitted_strap,
   input wire ain_scale_pkg::od_req_t  od_req,
   input wire ain_scale_pkg::od_rsp_t  od_rsp,
   input wire logic [31:0]             ch1_value,
   input wire logic [31:0]             ch2_value,
   input wire logic [7:0]              entry_count
);
   logic [6:0] quiet_r;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   // idle cycles since the last sample; a running result, then channel 1 and
   // channel 2 still queued, can move a value up to 105 cycles after it
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n)
         quiet_r <= 7'h00;
      else if (adc_smp.valid)
         quiet_r <= 7'h00;
      else if (quiet_r != 7'h7F)
         quiet_r <= quiet_r + 7'h01;
   end
   a_ack_follows: assert property ((od_req.rd || od_req.wr) |=> od_rsp.ack)
      else $error("request without answer");
   a_ack_cause: assert property (od_rsp.ack |-> $past(od_req.rd || od_req.wr))
      else $error("answer without request");
   a_value_ro: assert property ((od_req.wr && !od_req.rd && od_req.index == 16'h3320)
      |=> od_rsp.err)
      else $error("write to channel value accepted");
   a_count_ro: assert property ((od_req.wr && !od_req.rd && od_req.sub == 8'h00)
      |=> od_rsp.err)
      else $error("write to entry count accepted");
   a_count_legal: assert property (entry_count == 8'h01 || entry_count == 8'h02)
      else $error("entry count out of range");
   a_ch2_absent: assert property (entry_count == 8'h01 |-> ch2_value == 32'h0000_0000)
      else $error("channel two value without channel two");
   a_value_idle: assert property (quiet_r > 7'h6E
      |-> $stable(ch1_value) && $stable(ch2_value))
      else $error("channel value moved with no sample");
   a_value_read: assert property ((od_req.rd && od_req.index == 16'h3320 && od_req.sub == 8'h01)
      |=> !od_rsp.err && od_rsp.rdata == $past(ch1_value))
      else $error("channel one read mismatch");
   a_count_read: assert property ((od_req.rd && od_req.index == 16'h3320 && od_req.sub == 8'h00)
      |=> od_rsp.rdata == {24'h000000, $past(entry_count)})
      else $error("entry count read mismatch");
   a_param_sext: assert property ((od_req.rd && od_req.index != 16'h3320 && od_req.sub != 8'h00)
      |=> od_rsp.err || od_rsp.rdata[31:16] == {16{od_rsp.rdata[15]}})
      else $error("parameter read not sign extended");
   a_rdata_hold: assert property (!(od_req.rd || od_req.wr) |=> $stable(od_rsp.rdata))
      else $error("read data moved without request");
endmodule // ain_scale_props
bind ain_scale ain_scale_props ain_scale_props_inst (.core_clk(core_clk), .rst_n(rst_n),
   .adc_smp(adc_smp), .ch2_fitted_strap(ch2_fitted_strap), .od_req(od_req), .od_rsp(od_rsp),
   .ch1_value(ch1_value), .ch2_value(ch2_value), .entry_count(entry_count));
`default_nettype wire

// *** verification/od_master.sv ***
// Purpose: fieldbus master model issuing dictionary requests
// Assumes: one request per call, launched on a rising edge
// Notes:   the answer is taken once the ack edge has settled
`timescale 1ns/10ps
`default_nettype none
module od_master (
   input  wire logic                   core_clk,
   output var  ain_scale_pkg::od_req_t od_req,
   input  wire ain_scale_pkg::od_rsp_t od_rsp
);
   // idle at time zero so reset never sees a request
   initial od_req = '0;
   // one-cycle pulse; whole request dropped after the taking edge
   task automatic xfer(input logic wr, input logic [15:0] idx, input logic [7:0] sub,
                       input logic [31:0] wd, output ain_scale_pkg::od_rsp_t rsp);
      @(posedge core_clk);
      od_req <= '{rd: !wr, wr: wr, index: idx, sub: sub, wdata: wd};
      @(posedge core_clk);
      od_req <= '0;
      #1 rsp = od_rsp;
   endtask
endmodule // od_master
`default_nettype wire

// *** verification/analog_input_scaling_tb_top.sv ***
// Purpose: self-checking bench of the analog input scaling block
// Assumes: strap high first, low after a second reset
// Notes:   result latency of 35 cycles covered by a 40-cycle wait
`timescale 1ns/10ps
`default_nettype none
module analog_input_scaling_tb_top;
   typedef struct packed {
      logic wr; logic [15:0] idx; logic [7:0] sub; logic [31:0] wd; logic err; logic [31:0] rd;
   } row_t;
   logic                    core_clk = 1'b0;
   logic                    rst_n = 1'b0;
   logic                    strap = 1'b1;
   ain_scale_pkg::adc_smp_t adc_smp = '0;
   ain_scale_pkg::od_req_t  od_req;
   ain_scale_pkg::od_rsp_t  od_rsp, rsp;
   logic [31:0]             ch1_value, ch2_value;
   logic [7:0]              entry_count;
   int                      errors = 0, n_compared = 0, cyc = 0;
   // reset values, refusals and a signed write read back
   row_t rows [12] = '{'{1'h0, 16'h3320, 8'h01, 32'h0, 1'h0, 32'h0},
      '{1'h0, 16'h3321, 8'h01, 32'h0, 1'h0, 32'h0}, '{1'h0, 16'h3322, 8'h01, 32'h0, 1'h0, 32'hFFF},
      '{1'h0, 16'h3323, 8'h01, 32'h0, 1'h0, 32'hFFF}, '{1'h0, 16'h3320, 8'h00, 32'h0, 1'h0, 32'h2},
      '{1'h0, 16'h3322, 8'h02, 32'h0, 1'h0, 32'hFFF}, '{1'h1, 16'h3320, 8'h01, 32'h5, 1'h1, 32'h0},
      '{1'h1, 16'h3321, 8'h00, 32'h5, 1'h1, 32'h0}, '{1'h1, 16'h3321, 8'h01, 32'hFFF0, 1'h0, 32'h0},
      '{1'h0, 16'h3321, 8'h01, 32'h0, 1'h0, 32'hFFFFFFF0},
      '{1'h0, 16'h3324, 8'h01, 32'h0, 1'h1, 32'h0}, '{1'h0, 16'h3320, 8'h03, 32'h0, 1'h1, 32'h0}};
   ain_scale ain_scale_inst (.core_clk(core_clk), .rst_n(rst_n), .adc_smp(adc_smp),
      .ch2_fitted_strap(strap), .od_req(od_req), .od_rsp(od_rsp), .ch1_value(ch1_value),
      .ch2_value(ch2_value), .entry_count(entry_count));
   od_master od_master_inst (.core_clk(core_clk), .od_req(od_req), .od_rsp(od_rsp));
   // 250 MHz clock
   initial begin
      forever #2 core_clk = ~core_clk;
   end
   task automatic summarize();
      $display("compared %0d, mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         errors++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   // one sample pulse, then wait past the fixed result latency
   task automatic smp(input logic ch, input logic [9:0] d);
      @(posedge core_clk);
      adc_smp <= '{1'b1, ch, d};
      @(posedge core_clk);
      adc_smp.valid <= 1'b0;
      repeat (40) @(posedge core_clk);
      #1;
   endtask
   // truncation toward zero, as the divider does
   function automatic logic [31:0] scale(input longint raw, off, num, den);
      return 32'((raw + off) * num / den);
   endfunction
   // the run takes under 1000 cycles; a hang is cut off well past that
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         errors++;
         summarize();
      end
   end
   initial begin
      repeat (10) @(posedge core_clk);
      chk(ch1_value, 32'h0);
      $display("test reset values done");
      rst_n <= 1'b1;
      repeat (8) @(posedge core_clk);
      foreach (rows[i]) begin
         od_master_inst.xfer(rows[i].wr, rows[i].idx, rows[i].sub, rows[i].wd, rsp);
         chk({rsp.ack, rsp.err}, {1'b1, rows[i].err});
         if (!rows[i].err)
            chk(rsp.rdata, rows[i].rd);
      end
      $display("test dictionary rows done");
      smp(1'b1, 10'd300);
      chk(ch2_value, 32'd300);
      od_master_inst.xfer(1'b1, 16'h3322, 8'h01, 32'h3, rsp);
      od_master_inst.xfer(1'b1, 16'h3323, 8'h01, 32'h2, rsp);
      smp(1'b0, 10'd5);
      chk(ch1_value, scale(5, -16, 3, 2));
      od_master_inst.xfer(1'b1, 16'h3321, 8'h01, 32'h0, rsp);
      od_master_inst.xfer(1'b1, 16'h3322, 8'h01, 32'(ain_scale_pkg::CUR_FS_UA), rsp);
      od_master_inst.xfer(1'b1, 16'h3323, 8'h01, 32'(ain_scale_pkg::CUR_MAX_CNT), rsp);
      smp(1'b0, 10'd511);
      chk(ch1_value,
          scale(511, 0, ain_scale_pkg::CUR_FS_UA, ain_scale_pkg::CUR_MAX_CNT));
      od_master_inst.xfer(1'b1, 16'h3323, 8'h01, 32'h0, rsp);
      smp(1'b0, 10'd100);
      chk(ch1_value,
          scale(511, 0, ain_scale_pkg::CUR_FS_UA, ain_scale_pkg::CUR_MAX_CNT));
      $display("test scaling done");
      @(posedge core_clk);
      strap <= 1'b0;
      rst_n <= 1'b0;
      repeat (10) @(posedge core_clk);
      rst_n <= 1'b1;
      repeat (8) @(posedge core_clk);
      smp(1'b1, 10'd7);
      od_master_inst.xfer(1'b0, 16'h3320, 8'h02, 32'h0, rsp);
      chk(rsp.err, 1'b1);
      chk(entry_count, 8'h01);
      chk(ch2_value, 32'h0);
      chk(ch1_value, 32'h0);
      $display("test unfitted channel done");
      repeat (120) @(posedge core_clk);
      summarize();
   end
endmodule // analog_input_scaling_tb_top
`default_nettype wire
